/* icache_pkg.sv */
package icache_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int TAG_W = 22;
  localparam int TAG_LSB = 10;
  localparam int ROW_W = 5;
  localparam int ROW_LSB = 5;
  localparam int BANK_BIT = 10;
  localparam int SUB_W = 2;
  localparam int SUB_LSB = 3;
  localparam int LW_BIT = 2;
  localparam int NSUB = 4;
  localparam int NROWS = 32;
  localparam int NBANKS = 2;
  localparam int IO_BIT = 29;
  localparam logic [2:0] BUS_LEN_HEXA = 3'h5;
  localparam logic [2:0] BUS_LEN_QUAD = 3'h3;
  localparam logic [NSUB-1:0] VALID_RST = 4'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] vaddr;
    logic [ADDR_W-1:0] paddr;
  } fetch_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [2:0] len;
    logic cacheable;
  } bus_req_s;

  typedef struct packed {
    logic tagPar;
    logic [TAG_W-1:0] tag;
    logic [NSUB-1:0] valid;
    logic [NSUB-1:0] dataPar;
  } tag_entry_s;

  function automatic logic evenPar(input logic [DATA_W-1:0] d);
    evenPar = ^d;
  endfunction : evenPar

  function automatic logic tagParity(input logic [TAG_W-1:0] t);
    tagParity = ^t;
  endfunction : tagParity
endpackage : icache_pkg

/* icache_array.sv */
`timescale 1ns/1ns
`default_nettype none
module icache_array
  import icache_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Lookup port
  input wire logic [ROW_W+SUB_W:0] rdIdx,
  output logic [DATA_W-1:0] rdData,
  output tag_entry_s rdTag,
  // Write port
  input wire logic wrEn,
  input wire logic [ROW_W+SUB_W:0] wrIdx,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic tagWrEn,
  input wire tag_entry_s wrTag
);
  // Bank and row index into the tag store; subblock completes the data index
  localparam int NTAG = NROWS * NBANKS;
  logic [DATA_W-1:0] dataMem [0:NTAG*NSUB-1];
  tag_entry_s tagMem [0:NTAG-1];
  wire logic [ROW_W:0] rdRow = rdIdx[ROW_W+SUB_W:SUB_W];
  wire logic [ROW_W:0] wrRow = wrIdx[ROW_W+SUB_W:SUB_W];
  // Valid bits live in resettable flops so stale tags can never hit before a miss return fills them
  logic [NSUB-1:0] validMem [0:NTAG-1];
  logic [NSUB-1:0] rdValid;
  tag_entry_s tagRaw;

  // Data, tag, valid and parity read together in one cycle
  always_ff @(posedge ref_clk)
  begin
    rdData <= dataMem[rdIdx];
    tagRaw <= tagMem[rdRow];
    if (wrEn)
      dataMem[wrIdx] <= wrData;
    if (tagWrEn)
      tagMem[wrRow] <= wrTag;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdValid <= VALID_RST;
      for (int i = 0; i < NTAG; i++)
        validMem[i] <= VALID_RST;
    end
    else
    begin
      rdValid <= validMem[rdRow];
      if (tagWrEn)
        validMem[wrRow] <= wrTag.valid;
    end
  end

  assign rdTag = '{tagPar: tagRaw.tagPar, tag: tagRaw.tag, valid: rdValid, dataPar: tagRaw.dataPar};
endmodule : icache_array
`default_nettype wire

/* virtual_insn_cache.sv */
`timescale 1ns/1ns
`default_nettype none
module virtual_insn_cache
  import icache_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic cacheEnable,
  // Prefetcher request
  input wire logic reqValid,
  input wire fetch_req_s req,
  output logic reqReady,
  // Prefetch queue delivery
  output logic pqValid,
  output logic [DATA_W-1:0] pqData,
  output logic pqFromCache,
  // Primary cache request and return
  output logic pcReqValid,
  output bus_req_s pcReq,
  input wire logic pcReqReady,
  input wire logic pcRespValid,
  input wire logic [DATA_W-1:0] pcRespData,
  input wire logic pcRespHit,
  // System bus reference
  output logic busReqValid,
  output bus_req_s busReq,
  input wire logic busReqReady,
  // Status
  output logic tagParErr,
  output logic dataParErr
);
  typedef enum logic [2:0] {IDLE, LOOK, FWD, WAIT, BUS} state_e;
  state_e state_reg, state_next;
  fetch_req_s req_reg;
  logic enable_reg;
  logic pqValid_reg, pqFromCache_reg, pcReqValid_reg, busReqValid_reg;
  logic tagParErr_reg, dataParErr_reg;
  logic [DATA_W-1:0] pqData_reg;
  bus_req_s pcReq_reg, busReq_reg;

  wire logic [ROW_W+SUB_W:0] lookIdx;
  wire logic [ROW_W+SUB_W:0] reqIdx;
  wire logic [DATA_W-1:0] arrData;
  tag_entry_s arrTag;
  tag_entry_s fillTag;
  wire logic [SUB_W-1:0] sub;
  wire logic tagMatch, subValid, hit, tpOk, dpOk, cacheable, fillDone;

  // Virtual index: bank from bit 10, row from 9:5, subblock from 4:3
  assign reqIdx = {req.vaddr[BANK_BIT], req.vaddr[ROW_LSB+:ROW_W], req.vaddr[SUB_LSB+:SUB_W]};
  assign lookIdx = {req_reg.vaddr[BANK_BIT], req_reg.vaddr[ROW_LSB+:ROW_W], req_reg.vaddr[SUB_LSB+:SUB_W]};
  assign sub = req_reg.vaddr[SUB_LSB+:SUB_W];
  assign tagMatch = arrTag.tag == req_reg.vaddr[ADDR_W-1:TAG_LSB];
  assign subValid = arrTag.valid[sub];
  assign tpOk = tagParity(arrTag.tag) == arrTag.tagPar;
  assign dpOk = evenPar(arrData) == arrTag.dataPar[sub];
  // Parity failures fall back to a miss so bad data never reaches the queue
  assign hit = cacheable && tagMatch && subValid && tpOk && dpOk;
  assign cacheable = enable_reg && !req_reg.paddr[IO_BIT];
  assign fillDone = pcRespValid && state_reg == WAIT;

  // Fill forward: keep the tag if it matched, otherwise allocate the row fresh
  always_comb
  begin
    fillTag.tag = req_reg.vaddr[ADDR_W-1:TAG_LSB];
    fillTag.tagPar = tagParity(req_reg.vaddr[ADDR_W-1:TAG_LSB]);
    fillTag.valid = (tagMatch && tpOk) ? arrTag.valid : VALID_RST;
    fillTag.dataPar = (tagMatch && tpOk) ? arrTag.dataPar : VALID_RST;
    fillTag.valid[sub] = 1'b1;
    fillTag.dataPar[sub] = evenPar(pcRespData);
  end

  icache_array arrayInst (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .rdIdx(reqIdx),
    .rdData(arrData),
    .rdTag(arrTag),
    .wrEn(fillDone && cacheable),
    .wrIdx(lookIdx),
    .wrData(pcRespData),
    .tagWrEn(fillDone && cacheable),
    .wrTag(fillTag)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE: if (reqValid) state_next = LOOK;
      LOOK: state_next = hit ? IDLE : FWD;
      FWD: if (pcReqReady) state_next = WAIT;
      WAIT: if (pcRespValid) state_next = (pcRespHit && !req_reg.paddr[IO_BIT]) ? IDLE : BUS;
      BUS: if (busReqReady) state_next = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= IDLE;
      enable_reg <= 1'b0;
      req_reg <= '0;
      pqValid_reg <= 1'b0;
      pqFromCache_reg <= 1'b0;
      pqData_reg <= '0;
      pcReqValid_reg <= 1'b0;
      pcReq_reg <= '0;
      busReqValid_reg <= 1'b0;
      busReq_reg <= '0;
      tagParErr_reg <= 1'b0;
      dataParErr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      enable_reg <= cacheEnable;
      if (state_reg == IDLE && reqValid)
        req_reg <= req;
      pqValid_reg <= 1'b0;
      tagParErr_reg <= 1'b0;
      dataParErr_reg <= 1'b0;
      if (state_reg == LOOK)
      begin
        pqValid_reg <= hit;
        pqFromCache_reg <= 1'b1;
        pqData_reg <= arrData;
        tagParErr_reg <= enable_reg && !tpOk;
        dataParErr_reg <= enable_reg && tagMatch && tpOk && subValid && !dpOk;
        pcReqValid_reg <= !hit;
        pcReq_reg.addr <= {req_reg.paddr[ADDR_W-1:SUB_LSB], 3'h0};
        pcReq_reg.len <= BUS_LEN_QUAD;
        pcReq_reg.cacheable <= cacheable;
      end
      if (state_reg == FWD && pcReqReady)
        pcReqValid_reg <= 1'b0;
      if (fillDone)
      begin
        pqValid_reg <= 1'b1;
        pqFromCache_reg <= 1'b0;
        pqData_reg <= pcRespData;
        // One hexaword reference of the same type when no level held it
        // I/O space is never held by any level, so it always goes out
        busReqValid_reg <= !pcRespHit || req_reg.paddr[IO_BIT];
        busReq_reg.addr <= {req_reg.paddr[ADDR_W-1:ROW_LSB], 5'h00};
        busReq_reg.len <= BUS_LEN_HEXA;
        busReq_reg.cacheable <= cacheable;
      end
      if (state_reg == BUS && busReqReady)
        busReqValid_reg <= 1'b0;
    end
  end

  assign reqReady = state_reg == IDLE;
  assign pqValid = pqValid_reg;
  assign pqData = pqData_reg;
  assign pqFromCache = pqFromCache_reg;
  assign pcReqValid = pcReqValid_reg;
  assign pcReq = pcReq_reg;
  assign busReqValid = busReqValid_reg;
  assign busReq = busReq_reg;
  assign tagParErr = tagParErr_reg;
  assign dataParErr = dataParErr_reg;
endmodule : virtual_insn_cache
`default_nettype wire

/* vic_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module vic_monitor
  import icache_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  input wire logic arst_n,
  // Fetch
  input wire logic cacheEnable,
  input wire logic reqValid,
  input wire fetch_req_s req,
  input wire logic reqReady,
  input wire logic pqValid,
  input wire logic pqFromCache,
  // Next level
  input wire logic pcReqValid,
  input wire bus_req_s pcReq,
  input wire logic pcRespValid,
  input wire logic busReqValid,
  input wire bus_req_s busReq,
  input wire logic busReqReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence taken_s;
    reqValid && reqReady;
  endsequence
  look_time_a: assert property (taken_s |-> ##2 (pqValid && pqFromCache || pcReqValid))
    else $error("lookup answer late");
  off_miss_a: assert property (!cacheEnable [*2] ##0 taken_s |-> ##2 pcReqValid)
    else $error("disabled cache answered");
  io_miss_a: assert property (taken_s ##0 req.paddr[IO_BIT] |-> ##2 pcReqValid)
    else $error("io fetch served from cache");
  resp_pq_a: assert property (pcRespValid |=> pqValid && !pqFromCache)
    else $error("return not delivered");
  pc_quad_a: assert property (pcReqValid |-> pcReq.len == BUS_LEN_QUAD && pcReq.addr[2:0] == 3'h0)
    else $error("bad forwarded size");
  bus_hexa_a: assert property (busReqValid |-> busReq.len == BUS_LEN_HEXA && busReq.addr[4:0] == 5'h0)
    else $error("bad bus size");
  bus_once_a: assert property (busReqValid && busReqReady |=> !busReqValid)
    else $error("bus reference repeated");
  hit_quiet_a: assert property (pqValid && pqFromCache |-> !pcReqValid && !busReqValid)
    else $error("hit went outward");
  io_flag_a: assert property (busReqValid && busReq.addr[IO_BIT] |-> !busReq.cacheable)
    else $error("io marked cacheable");
endmodule : vic_monitor
bind virtual_insn_cache vic_monitor monitor (.*);
`default_nettype wire

/* vic_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module vic_partner
  import icache_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic hitMode,
  output int nPc,
  output int nBus,
  output bus_req_s lastPc,
  output bus_req_s lastBus,
  // Primary cache
  input wire logic pcReqValid,
  input wire bus_req_s pcReq,
  output logic pcReqReady,
  output logic pcRespValid,
  output logic [DATA_W-1:0] pcRespData,
  output logic pcRespHit,
  // System bus
  input wire logic busReqValid,
  input wire bus_req_s busReq,
  output logic busReqReady
);
  initial
  begin
    {pcReqReady, pcRespValid, pcRespHit, busReqReady} = 4'h0;
    pcRespData = '0;
    nPc = 0;
    nBus = 0;
    forever
    begin
      @(posedge ref_clk);
      if (pcReqValid === 1'b1)
      begin
        repeat (nPc % 3) @(posedge ref_clk); // Mix prompt and slow grants
        pcReqReady <= 1'b1;
        @(posedge ref_clk);
        lastPc = pcReq;
        nPc++;
        pcReqReady <= 1'b0;
        repeat (nPc % 2 + 1) @(posedge ref_clk);
        pcRespValid <= 1'b1;
        pcRespHit <= hitMode;
        pcRespData <= {~lastPc.addr, lastPc.addr};
        @(posedge ref_clk);
        pcRespValid <= 1'b0;
        pcRespData <= {lastPc.addr, ~lastPc.addr}; // Stale data must not be reused
      end
    end
  end
  always @(posedge ref_clk)
  begin
    busReqReady <= busReqValid && !busReqReady;
    if (busReqValid && busReqReady)
    begin
      lastBus = busReq;
      nBus++;
    end
  end
endmodule : vic_partner
`default_nettype wire

/* virtual_insn_cache_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin nFail++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module virtual_insn_cache_test
  import icache_pkg::*;
;
  localparam logic [31:0] VA = 32'h0000_1260;
  localparam logic [31:0] PA = 32'h0004_a260;
  logic ref_clk, arst_n, cacheEnable, reqValid, reqReady, pqValid, pqFromCache, pcReqValid, pcReqReady;
  logic pcRespValid, pcRespHit, busReqValid, busReqReady, hitMode, tagParErr, dataParErr;
  logic [DATA_W-1:0] pqData, pcRespData;
  fetch_req_s req;
  bus_req_s pcReq, busReq, lastPc, lastBus;
  int nPc, nBus, nFail = 0, checkCount = 0;
  virtual_insn_cache DUT (.*);
  vic_partner model (.*);
  task automatic fetch(input logic [31:0] va, input logic [31:0] pa, input logic hit, input logic bus);
    int p0, b0, k;
    logic [31:0] a;
    p0 = nPc;
    b0 = nBus;
    k = 0;
    a = {pa[31:3], 3'h0};
    reqValid <= 1'b1;
    req <= '{va, pa};
    @(posedge ref_clk);
    while (reqReady !== 1'b1 && k++ < 50) @(posedge ref_clk);
    reqValid <= 1'b0;
    while (pqValid !== 1'b1 && k++ < 200) @(posedge ref_clk);
    `CHK({pqValid, pqFromCache}, {1'b1, hit})
    `CHK(pqData, {~a, a})
    repeat (4) @(posedge ref_clk);
    `CHK(nPc - p0, int'(!hit))
    `CHK(nBus - b0, int'(bus))
    if (!hit) `CHK({lastPc.addr, lastPc.len}, {a, BUS_LEN_QUAD})
    if (bus) `CHK({lastBus.addr, lastBus.len}, {pa[31:5], 5'h0, BUS_LEN_HEXA})
  endtask : fetch
  task automatic testOff;
    `CHK({reqReady, pqValid, pcReqValid, busReqValid}, 4'h8)
    hitMode <= 1'b1;
    fetch(VA, PA, 1'b0, 1'b0);
    fetch(VA, PA, 1'b0, 1'b0);
    $display("off done");
  endtask : testOff
  task automatic testFill;
    cacheEnable <= 1'b1;
    hitMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    fetch(VA, PA, 1'b0, 1'b1);
    fetch(VA, PA, 1'b1, 1'b0);
    fetch(VA + 4, PA + 4, 1'b1, 1'b0);
    fetch(VA + 8, PA + 8, 1'b0, 1'b1);
    fetch(VA, PA, 1'b1, 1'b0);
    $display("fill done");
  endtask : testFill
  task automatic testTag;
    fetch(VA ^ 32'h1000, PA ^ 32'h8000, 1'b0, 1'b1);
    fetch(VA ^ 32'h0400, PA ^ 32'h4000, 1'b0, 1'b1);
    fetch(VA ^ 32'h1000, PA ^ 32'h8000, 1'b1, 1'b0);
    fetch(VA, PA, 1'b0, 1'b1);
    $display("tag done");
  endtask : testTag
  task automatic testIo;
    fetch(32'h0000_7000, 32'h2000_7000, 1'b0, 1'b1);
    `CHK(lastBus.cacheable, 1'b0)
    fetch(32'h0000_7000, 32'h2000_7000, 1'b0, 1'b1);
    hitMode <= 1'b1;
    fetch(32'h0000_7000, 32'h2000_7000, 1'b0, 1'b1);
    $display("io done");
  endtask : testIo
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : printVerdict
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    {arst_n, cacheEnable, reqValid, hitMode} = 4'h0;
    req = '0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    testOff();
    testFill();
    testTag();
    testIo();
    printVerdict();
  end
  initial
  begin
    #50000;
    nFail++;
    printVerdict();
  end
endmodule : virtual_insn_cache_test
`default_nettype wire
